//--- core/sapc_pkg.sv
/*
  Package for the successive-approximation converter controller: register byte
  addresses, field positions, reset values, conversion-time table and states.
  Assumes an 8-bit CPU data bus with 16-bit result reads on a 50 MHz clock.
*/
package sapc_pkg;
  // register byte addresses
  localparam logic [15:0] ADDR_RESULT_LO = 16'hFF08;
  localparam logic [15:0] ADDR_RESULT_HI = 16'hFF09;
  localparam logic [15:0] ADDR_MODE = 16'hFF28;
  localparam logic [15:0] ADDR_CHANNEL = 16'hFF29;
  localparam logic [15:0] ADDR_CMP_MODE = 16'hFF2A;
  localparam logic [15:0] ADDR_THRESHOLD = 16'hFF2B;
  // field positions
  localparam int MODE_START_POS = 7;
  localparam int MODE_REF_EN_POS = 0;
  localparam int MODE_TSEL_LSB = 3;
  localparam int CMP_ENABLE_POS = 7;
  localparam int CMP_POLARITY_POS = 6;
  localparam int CHANNEL_BITS = 3;
  localparam int RESULT_SHIFT = 6;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_RESET = 8'h00;
  localparam logic [7:0] CMP_MODE_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  // writable masks: reserved bits read as zero
  localparam logic [7:0] MODE_MASK = 8'hB9;
  localparam logic [7:0] CHANNEL_MASK = 8'h07;
  localparam logic [7:0] CMP_MODE_MASK = 8'hC0;
  // conversion time in main clock periods per code
  localparam logic [8:0] CONV_T0 = 9'd288;
  localparam logic [8:0] CONV_T1 = 9'd240;
  localparam logic [8:0] CONV_T2 = 9'd192;
  localparam logic [8:0] CONV_T4 = 9'd144;
  localparam logic [8:0] CONV_T5 = 9'd120;
  localparam logic [8:0] CONV_T6 = 9'd96;
  // ten approximation steps, each one compare cycle
  localparam int SAR_BITS = 10;
  localparam logic [8:0] STEP_CYCLES = 9'd10;
  // reference settle time, for software reference only
  localparam int REF_SETTLE_US = 14;
  localparam int CLK_MHZ = 50;
  localparam int REF_SETTLE_CYCLES = REF_SETTLE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    SAPC_IDLE = 2'b00,
    SAPC_SAMPLE = 2'b01,
    SAPC_CONVERT = 2'b11,
    SAPC_DONE = 2'b10
  } sapc_state_e;
endpackage

//--- core/sapc_sar_step.sv
/*
  Successive approximation core: given the held comparator answer it walks a
  trial code from bit nine down to bit zero, one bit per start/step pulse.
  Assumes the comparator answers the tap shown on trial_code in the same cycle.
*/
module sapc_sar_step
  import sapc_pkg::*;
#(
  parameter int WIDTH = SAR_BITS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic begin_conv,
  input wire logic step,
  input wire logic cmp_ge,
  output logic [WIDTH-1:0] trial_code,
  output logic last_bit
);
  logic [WIDTH-1:0] code;
  logic [WIDTH-1:0] probe;
  logic [WIDTH-1:0] next_code;
  logic [WIDTH-1:0] next_probe;

  // keep the probed bit when input >= tap, then trial the next lower bit
  always_comb
  begin
    next_code = code;
    next_probe = probe;
    if (begin_conv)
    begin
      next_probe = {1'b1, {(WIDTH-1){1'b0}}};
      next_code = next_probe;
    end
    else if (step && probe != '0)
    begin
      next_code = cmp_ge ? code : (code & ~probe);
      next_probe = probe >> 1;
      next_code = next_code | next_probe;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      code <= '0;
      probe <= '0;
    end
    else
    begin
      code <= next_code;
      probe <= next_probe;
    end
  end

  assign trial_code = code;
  assign last_bit = probe[0];
endmodule

//--- core/sapc_ctrl.sv
/*
  Converter controller: CPU-side registers, channel select, sample/hold timing,
  approximation sequencing, result latch and threshold-gated end-of-conversion
  request. Assumes the CPU presents one access per cycle and holds it while
  bus_wait is high; the analog front end answers cmp_ge for the shown tap.
*/
module sapc_ctrl
  import sapc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_bit_op,
  input wire logic [2:0] bus_bit_sel,
  input wire logic [7:0] bus_wdata,
  input wire logic cmp_ge,
  output logic [15:0] bus_rdata,
  output logic bus_wait,
  output logic [7:0] analog_sel,
  output logic sample_en,
  output logic ref_enable,
  output logic [SAR_BITS-1:0] tap_code,
  output logic conversion_end_irq
);
  logic [7:0] converter_mode_reg;
  logic [7:0] input_channel_select;
  logic [7:0] powerfail_compare_mode;
  logic [7:0] powerfail_threshold;
  logic [15:0] conversion_result;
  sapc_state_e state;
  logic [8:0] cnt;
  logic [7:0] next_mode, next_chan, next_cmp, next_thr;
  logic [15:0] next_result, next_rdata;
  sapc_state_e next_state;
  logic [8:0] next_cnt;
  logic next_wait, next_irq, next_sample;
  logic [7:0] next_sel;
  logic wr_mode, wr_chan, wr_cmp, wr_thr, any_wr, rd_result;
  logic begin_conv, step, last_bit, irq_ok, conversion_start_bit;
  logic [SAR_BITS-1:0] trial_code;
  logic [8:0] sample_len;

  // bit-op writes touch one bit; byte writes replace all writable bits
  function automatic logic [7:0] merge_write(input logic [7:0] cur, input logic [7:0] mask,
                                             input logic bit_op, input logic [2:0] sel,
                                             input logic [7:0] wd);
    logic [7:0] onehot;
    onehot = 8'h01 << sel;
    if (bit_op)
      merge_write = ((cur & ~onehot) | (wd & onehot)) & mask;
    else
      merge_write = wd & mask;
  endfunction

  // whole-conversion length per time code; prohibited codes fall back to longest
  function automatic logic [8:0] conv_len(input logic [2:0] code);
    case (code)
      3'h0: conv_len = CONV_T0;
      3'h1: conv_len = CONV_T1;
      3'h2: conv_len = CONV_T2;
      3'h4: conv_len = CONV_T4;
      3'h5: conv_len = CONV_T5;
      3'h6: conv_len = CONV_T6;
      default: conv_len = CONV_T0;
    endcase
  endfunction

  assign wr_mode = bus_wr && bus_addr == ADDR_MODE;
  assign wr_chan = bus_wr && bus_addr == ADDR_CHANNEL;
  assign wr_cmp = bus_wr && bus_addr == ADDR_CMP_MODE;
  assign wr_thr = bus_wr && !bus_bit_op && bus_addr == ADDR_THRESHOLD;
  assign any_wr = wr_mode || wr_chan || wr_cmp || wr_thr;
  assign rd_result = bus_rd && bus_addr == ADDR_RESULT_LO;
  assign conversion_start_bit = converter_mode_reg[MODE_START_POS];
  // tap comes straight from the approximation flop, so cmp_ge answers the code being decided
  assign tap_code = trial_code;
  // time left after ten compare cycles and a done cycle goes to sampling
  assign sample_len = conv_len(converter_mode_reg[MODE_TSEL_LSB +: 3]) - STEP_CYCLES - 9'd1;

  // unsigned compare of upper result byte against threshold
  assign irq_ok = !powerfail_compare_mode[CMP_ENABLE_POS] ? 1'b1 :
                  (powerfail_compare_mode[CMP_POLARITY_POS] ?
                   (trial_code[9:2] < powerfail_threshold) :
                   (trial_code[9:2] >= powerfail_threshold));

  // register file; rejected bit writes to threshold are ignored
  always_comb
  begin
    next_mode = wr_mode ? merge_write(converter_mode_reg, MODE_MASK, bus_bit_op, bus_bit_sel, bus_wdata)
                        : converter_mode_reg;
    next_chan = wr_chan ? merge_write(input_channel_select, CHANNEL_MASK, bus_bit_op, bus_bit_sel, bus_wdata)
                        : input_channel_select;
    next_cmp = wr_cmp ? merge_write(powerfail_compare_mode, CMP_MODE_MASK, bus_bit_op, bus_bit_sel, bus_wdata)
                      : powerfail_compare_mode;
    next_thr = wr_thr ? bus_wdata : powerfail_threshold;
    next_wait = (any_wr || rd_result) && !bus_wait;
    next_rdata = 16'h0000;
    if (rd_result)
      next_rdata = conversion_result;
    else if (bus_rd)
    begin
      case (bus_addr)
        ADDR_MODE: next_rdata = {8'h00, converter_mode_reg};
        ADDR_CHANNEL: next_rdata = {8'h00, input_channel_select};
        ADDR_CMP_MODE: next_rdata = {8'h00, powerfail_compare_mode};
        ADDR_THRESHOLD: next_rdata = {8'h00, powerfail_threshold};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // conversion sequencer: sample, ten steps, latch, repeat
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_result = conversion_result;
    next_irq = 1'b0;
    begin_conv = 1'b0;
    step = 1'b0;
    case (state)
      SAPC_IDLE:
      begin
        if (conversion_start_bit)
        begin
          next_state = SAPC_SAMPLE;
          next_cnt = sample_len;
        end
      end
      SAPC_SAMPLE:
      begin
        if (cnt <= 9'd1)
        begin
          next_state = SAPC_CONVERT;
          begin_conv = 1'b1;
        end
        else
          next_cnt = cnt - 9'd1;
      end
      SAPC_CONVERT:
      begin
        step = 1'b1;
        if (last_bit)
          next_state = SAPC_DONE;
      end
      SAPC_DONE:
      begin
        next_result = {trial_code, 6'h00};
        next_irq = irq_ok;
        next_state = SAPC_SAMPLE;
        next_cnt = sample_len;
      end
      default: next_state = SAPC_IDLE;
    endcase
    // a write aborts the running conversion; start bit decides restart
    if (any_wr && state != SAPC_IDLE)
    begin
      next_state = SAPC_IDLE;
      next_irq = 1'b0;
      if (!next_mode[MODE_START_POS])
        next_result = conversion_result;
    end
    if (!conversion_start_bit)
      next_state = SAPC_IDLE;
  end

  // outputs to the analog front end
  always_comb
  begin
    next_sel = 8'h01 << input_channel_select[CHANNEL_BITS-1:0];
    next_sample = next_state == SAPC_SAMPLE;
  end

  sapc_sar_step #(
    .WIDTH(SAR_BITS)
  ) u_sar (
    .clk(clk),
    .sys_rst(sys_rst),
    .begin_conv(begin_conv),
    .step(step),
    .cmp_ge(cmp_ge),
    .trial_code(trial_code),
    .last_bit(last_bit)
  );

  // result holds no reset value: unset until the first conversion completes
  always_ff @(posedge clk)
  begin
    conversion_result <= next_result;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      converter_mode_reg <= MODE_RESET;
      input_channel_select <= CHANNEL_RESET;
      powerfail_compare_mode <= CMP_MODE_RESET;
      powerfail_threshold <= THRESHOLD_RESET;
      state <= SAPC_IDLE;
      cnt <= 9'h000;
      bus_wait <= 1'b0;
      bus_rdata <= 16'h0000;
      conversion_end_irq <= 1'b0;
      analog_sel <= 8'h01;
      sample_en <= 1'b0;
      ref_enable <= 1'b0;
    end
    else
    begin
      converter_mode_reg <= next_mode;
      input_channel_select <= next_chan;
      powerfail_compare_mode <= next_cmp;
      powerfail_threshold <= next_thr;
      state <= next_state;
      cnt <= next_cnt;
      bus_wait <= next_wait;
      bus_rdata <= next_rdata;
      conversion_end_irq <= next_irq;
      analog_sel <= next_sel;
      sample_en <= next_sample;
      ref_enable <= next_mode[MODE_REF_EN_POS];
    end
  end

  // wait cycle lasts exactly one clock after a result read
  a_wait_one: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_result && !bus_wait) |=> bus_wait ##1 !bus_wait)
    else $error("wait not one cycle");

  sequence s_done;
    state == SAPC_DONE && !any_wr && conversion_start_bit;
  endsequence

  a_result_load: assert property (@(posedge clk) disable iff (sys_rst)
    s_done |=> conversion_result == {$past(trial_code), 6'h00})
    else $error("result not latched");

  a_low_zero: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state) == SAPC_DONE |-> conversion_result[5:0] == 6'h00)
    else $error("low result bits not zero");

  a_stop_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !conversion_start_bit |=> state == SAPC_IDLE)
    else $error("stop did not idle");

  a_abort_write: assert property (@(posedge clk) disable iff (sys_rst)
    (any_wr && state != SAPC_IDLE) |=> state == SAPC_IDLE && !conversion_end_irq)
    else $error("write did not abort");

  a_irq_ge: assert property (@(posedge clk) disable iff (sys_rst)
    (s_done and powerfail_compare_mode[7:6] == 2'b10 && trial_code[9:2] < powerfail_threshold)
    |=> !conversion_end_irq)
    else $error("irq raised below threshold");

  a_plain_irq: assert property (@(posedge clk) disable iff (sys_rst)
    (s_done and !powerfail_compare_mode[CMP_ENABLE_POS]) |=> conversion_end_irq)
    else $error("plain conversion lacked irq");

  a_ten_steps: assert property (@(posedge clk) disable iff (sys_rst)
    (begin_conv && !any_wr && conversion_start_bit) |=> (state == SAPC_CONVERT)[*1] ##10 state == SAPC_DONE
      || any_wr || !conversion_start_bit)
    else $error("approximation length wrong");

  a_sel_onehot: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 analog_sel == (8'h01 << $past(input_channel_select[2:0])))
    else $error("channel select mismatch");

  a_thr_byte: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_wr && bus_bit_op && bus_addr == ADDR_THRESHOLD) |=> $stable(powerfail_threshold))
    else $error("threshold took bit write");
endmodule

//--- bench/sapc_analog_model.sv
/*
  Behavioural far side of the converter: eight analog inputs given as 10-bit
  codes, a sample/hold node and the comparator against the resistor-string tap.
  Assumes the controller shows tap_code and reads cmp_ge in the same cycle.
*/
module sapc_analog_model
(
  input wire logic clk,
  input wire logic [7:0] analog_sel,
  input wire logic sample_en,
  input wire logic [9:0] tap_code,
  input wire logic [9:0] vin [8],
  output logic cmp_ge
);
  timeunit 1ns;
  timeprecision 100ps;
  // held node starts at an odd level so a missed sample shows as a wrong code
  logic [9:0] held = 10'h2AA;

  // track the selected input only while sampling, freeze it on hold
  always @(posedge clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (sample_en && analog_sel[i]) held <= vin[i];
    end
  end

  // input at or above the tap keeps the trial bit
  assign cmp_ge = (held >= tap_code);
endmodule

//--- bench/sapc_ctrl_tb.sv
/*
  Self-checking bench for the converter controller: register access, channel
  select, conversion timing, results, threshold-gated request, stop and abort.
  Assumes one-cycle strobes, answers one cycle after the access edge.
*/
module sapc_ctrl_tb;
  import sapc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, bus_wr, bus_rd, bus_bit_op, cmp_ge, bus_wait, sample_en, ref_enable, conversion_end_irq;
  logic [15:0] bus_addr, bus_rdata;
  logic [2:0] bus_bit_sel;
  logic [7:0] bus_wdata, analog_sel;
  logic [9:0] tap_code;
  logic [9:0] vin [8];
  logic [17:0] exp_q [$];
  logic acc_q;
  int err_count, checked, n;
  logic [7:0] up;
  int lens [7] = '{288, 240, 192, 144, 120, 96, 288};
  int codes [7] = '{0, 1, 2, 4, 5, 6, 3};

  sapc_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_bit_op(bus_bit_op), .bus_bit_sel(bus_bit_sel), .bus_wdata(bus_wdata), .cmp_ge(cmp_ge),
    .bus_rdata(bus_rdata), .bus_wait(bus_wait), .analog_sel(analog_sel), .sample_en(sample_en),
    .ref_enable(ref_enable), .tap_code(tap_code), .conversion_end_irq(conversion_end_irq));
  sapc_analog_model u_analog (.clk(clk), .analog_sel(analog_sel), .sample_en(sample_en),
    .tap_code(tap_code), .vin(vin), .cmp_ge(cmp_ge));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one access, then skip the wait cycle before the next may start
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d, input logic bop, input logic [2:0] bs);
    @(posedge clk);
    #1;
    bus_addr = a;
    bus_wr = w;
    bus_rd = !w;
    bus_wdata = d;
    bus_bit_op = bop;
    bus_bit_sel = bs;
    @(posedge clk);
    #1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_bit_op = 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bop = 1'b0, input logic [2:0] bs = 3'h0,
                    input logic chkw = 1'b1);
    exp_q.push_back({1'b0, chkw, 16'h0000});
    acc(a, 1'b1, d, bop, bs);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic chkw = 1'b0);
    exp_q.push_back({1'b1, chkw, e});
    acc(a, 1'b0, 8'h00, 1'b0, 3'h0);
  endtask

  // counts cycles to the next end-of-conversion pulse, gives up at lim
  task automatic wait_irq(output int cnt, input int lim = 700);
    cnt = 0;
    do
    begin
      @(negedge clk);
      cnt++;
    end
    while (conversion_end_irq !== 1'b1 && cnt < lim);
  endtask

  // answers land one cycle after the access edge, so look at the falling edge
  always @(posedge clk) acc_q <= bus_wr | bus_rd;
  always @(negedge clk)
  begin
    logic [17:0] e;
    if (acc_q && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e[17]) check(bus_rdata, e[15:0]);
      check({15'h0000, bus_wait}, {15'h0000, e[16]});
    end
  end

  initial
  begin
    #400000;
    err_count++;
    final_report();
  end

  initial
  begin
    sys_rst = 1'b1;
    {bus_wr, bus_rd, bus_bit_op} = 3'h0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_bit_sel = 3'h0;
    void'($urandom(32'h0dac));
    for (int i = 0; i < 8; i++) vin[i] = 10'($urandom());
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    // reset state of outputs and registers
    check({8'h00, analog_sel}, 16'h0001);
    check({14'h0, ref_enable, conversion_end_irq}, 16'h0000);
    rd(ADDR_MODE, 16'h0000);
    rd(ADDR_CHANNEL, 16'h0000);
    rd(ADDR_CMP_MODE, 16'h0000);
    rd(ADDR_THRESHOLD, 16'h0000);
    rd(16'hFF30, 16'h0000);
    // every channel code drives exactly its own input
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_CHANNEL, 8'(c));
      // select output follows the register one cycle later
      @(posedge clk);
      #1;
      check({8'h00, analog_sel}, 16'h0001 << c);
    end
    wr(ADDR_CHANNEL, 8'h00);
    wr(ADDR_CHANNEL, 8'h04, 1'b1, 3'h2);
    rd(ADDR_CHANNEL, 16'h0004);
    wr(ADDR_THRESHOLD, 8'h5A);
    wr(ADDR_THRESHOLD, 8'h01, 1'b1, 3'h0, 1'b0);
    rd(ADDR_THRESHOLD, 16'h005A);
    wr(ADDR_THRESHOLD, 8'h00);
    // reference first, then let it settle before any start
    wr(ADDR_MODE, 8'h01);
    repeat (REF_SETTLE_CYCLES) @(negedge clk);
    // each time code sets the spacing of back-to-back conversions
    for (int k = 0; k < 7; k++)
    begin
      wr(ADDR_MODE, 8'h81 | 8'(codes[k] << MODE_TSEL_LSB));
      check({15'h0, ref_enable}, 16'h0001);
      wait_irq(n);
      wait_irq(n);
      check(16'(n), 16'(lens[k]));
    end
    wr(ADDR_MODE, 8'hB1);
    // results of every input, left-justified
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_CHANNEL, 8'(c));
      wait_irq(n);
      wait_irq(n);
      rd(ADDR_RESULT_LO, {vin[c], 6'h00}, 1'b1);
    end
    // threshold equal to the upper byte sits on the boundary
    wr(ADDR_CHANNEL, 8'h00);
    if (vin[0][9:2] == 8'hFF) vin[0] = 10'h3F0;
    up = vin[0][9:2];
    wr(ADDR_THRESHOLD, up);
    wr(ADDR_CMP_MODE, 8'h80);
    wait_irq(n, 250);
    check(16'(n < 250), 16'h0001);
    wr(ADDR_CMP_MODE, 8'h40, 1'b1, 3'h6);
    rd(ADDR_CMP_MODE, 16'h00C0);
    wait_irq(n, 250);
    check(16'(n), 16'd250);
    wr(ADDR_THRESHOLD, up + 8'h01);
    wait_irq(n, 250);
    check(16'(n < 250), 16'h0001);
    // upper byte below threshold with the at-or-above polarity stays silent
    wr(ADDR_CMP_MODE, 8'h80);
    wait_irq(n, 250);
    check(16'(n), 16'd250);
    wr(ADDR_CMP_MODE, 8'h00);
    // a register write mid-conversion restarts the count
    wait_irq(n);
    repeat (30) @(negedge clk);
    wr(ADDR_THRESHOLD, 8'h33);
    wait_irq(n);
    check(16'(n >= 90 && n <= 100), 16'h0001);
    // clearing start mid-conversion stops all further requests
    repeat (20) @(negedge clk);
    wr(ADDR_MODE, 8'h31);
    wait_irq(n, 400);
    check(16'(n), 16'd400);
    final_report();
  end
endmodule
